// [shared/narrow_load_pkg.sv]
// constants, types and register map for the signed narrow load unit
// assumes one clock, a synchronous reset and a 32-bit apb register bus
package narrow_load_pkg;

	// ****************************************************
	// register map (byte addresses on apb)
	// ****************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_LAST_ADDR = 8'h0c;
	localparam logic [7:0] OFF_LOAD_COUNT = 8'h10;

	// control fields and reset values
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TRAP_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [5:0] MASK_RESET = 6'h00;

	// event bits, same layout in status and mask
	localparam int EV_DONE = 0;
	localparam int EV_HINT = 1;
	localparam int EV_UNPRED = 2;
	localparam int EV_UNDEF = 3;
	localparam int EV_FAULT = 4;
	localparam int EV_FOREIGN = 5;
	localparam int NUM_EV = 6;

	// ****************************************************
	// encoding constants
	// ****************************************************
	localparam logic [3:0] REG_SP = 4'hd;
	localparam logic [3:0] REG_PC = 4'hf;
	localparam logic [11:0] HW1_USB = 12'hf91;
	localparam logic [11:0] HW1_SH_LONG_OFFSET_FIELD = 12'hf9b;
	localparam logic [11:0] HW1_SH_MAIN = 12'hf93;
	localparam logic [7:0] HW1_LOAD_HI = 8'hf9;
	localparam logic [2:0] HW1_BYTE_LO = 3'h1;
	localparam logic [2:0] HW1_HALF_LO = 3'h3;
	localparam logic [3:0] HW2_UNPRIV = 4'he;
	localparam logic [6:0] OP16_SH_REG = 7'h2f;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_USB = 4'h1,
		OP_SB_LIT = 4'h2,
		OP_SH_IMM = 4'h3,
		OP_SH_LIT = 4'h4,
		OP_SH_REG = 4'h5,
		OP_HINT = 4'h6,
		OP_FOREIGN = 4'h7,
		OP_UNDEF = 4'h8
	} op_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_REQ = 2'b01,
		S_WAIT = 2'b10
	} state_t;

	typedef struct packed {
		op_t op;
		logic [3:0] rt;
		logic [3:0] rn;
		logic [3:0] rm;
		logic [11:0] imm;
		logic [1:0] shift;
		logic index;
		logic add;
		logic wback;
		logic reg_form;
		logic lit;
		logic half;
		logic unpriv;
		logic unpred;
	} dec_t;

	typedef struct packed {
		logic [31:0] addr;
		logic half;
		logic unpriv;
	} mem_req_t;

	typedef struct packed {
		logic we;
		logic [3:0] idx;
		logic [31:0] data;
	} wb_t;

endpackage : narrow_load_pkg

// [rtl/narrow_load_decode.sv]
// decode and execute of signed byte and halfword loads
// assumes the pipeline supplies base, offset register and pc values
// read by the instruction's own fields, and a load unit answering once
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module narrow_load_decode
	import narrow_load_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	// issue side
	input wire logic issue_valid,
	output logic issue_ready_r,
	input wire logic [31:0] instr,
	input wire logic instr_wide,
	input wire logic [31:0] base_val,
	input wire logic [31:0] off_val,
	input wire logic [31:0] pc_val,
	// load unit side
	output logic mem_req_valid_r,
	output mem_req_t mem_req_r,
	input wire logic mem_req_ready,
	input wire logic mem_resp_valid,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_fault,
	// register writeback
	output wb_t rt_wb_r,
	output wb_t rn_wb_r,
	output logic done_r,
	output logic irq_r,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic is_sp_pc(input logic [3:0] r);
		return (r == REG_SP) || (r == REG_PC);
	endfunction : is_sp_pc

	function automatic dec_t decode_instr(input logic [31:0] ins,
		input logic wide);
		dec_t d;
		logic [15:0] h1;
		logic [15:0] h2;
		logic p;
		logic u;
		logic w;
		d = '0;
		d.op = OP_UNDEF;
		d.index = 1'b1;
		d.add = 1'b1;
		h1 = ins[31:16];
		h2 = ins[15:0];
		p = h2[10];
		u = h2[9];
		w = h2[8];
		if (!wide) begin
			if (h2[15:9] == OP16_SH_REG) begin
				d.op = OP_SH_REG;
				d.rm = {1'b0, h2[8:6]};
				d.rn = {1'b0, h2[5:3]};
				d.rt = {1'b0, h2[2:0]};
				d.half = 1'b1;
				d.reg_form = 1'b1;
			end
		end else begin
			d.rn = h1[3:0];
			d.rt = h2[15:12];
			d.rm = h2[3:0];
			d.imm = h2[11:0];
			d.half = (h1[6:4] == HW1_HALF_LO);
			if (h1[15:8] == HW1_LOAD_HI && h1[6:4] == HW1_BYTE_LO &&
				d.rn == REG_PC) begin
				// byte literal, reached from the unpriv byte encoding
				d.op = (d.rt == REG_PC) ? OP_HINT : OP_SB_LIT;
				d.lit = 1'b1;
				d.add = h1[7];
				d.unpred = (d.rt == REG_SP);
			end else if (h1[15:8] == HW1_LOAD_HI && d.half &&
				d.rn == REG_PC) begin
				d.op = (d.rt == REG_PC) ? OP_HINT : OP_SH_LIT;
				d.lit = 1'b1;
				d.add = h1[7];
				d.unpred = (d.rt == REG_SP);
			end else if (h1[15:4] == HW1_USB && h2[11:8] == HW2_UNPRIV) begin
				d.op = OP_USB;
				d.imm = {4'h0, h2[7:0]};
				d.unpriv = 1'b1;
				d.unpred = is_sp_pc(d.rt);
			end else if (h1[15:4] == HW1_SH_LONG_OFFSET_FIELD) begin
				d.op = (d.rt == REG_PC) ? OP_HINT : OP_SH_IMM;
				d.unpred = (d.rt == REG_SP);
			end else if (h1[15:4] == HW1_SH_MAIN && h2[11]) begin
				d.imm = {4'h0, h2[7:0]};
				d.index = p;
				d.add = u;
				d.wback = w;
				if (d.rt == REG_PC && p && !u && !w) begin
					d.op = OP_HINT;
				end else if (p && u && !w) begin
					d.op = OP_FOREIGN;
				end else if (!p && !w) begin
					d.op = OP_UNDEF;
				end else begin
					d.op = OP_SH_IMM;
					d.unpred = is_sp_pc(d.rt) || (w && d.rn == d.rt);
				end
			end else if (h1[15:4] == HW1_SH_MAIN && h2[11:6] == 6'h00) begin
				d.op = (d.rt == REG_PC) ? OP_HINT : OP_SH_REG;
				d.reg_form = 1'b1;
				d.shift = h2[5:4];
				d.unpred = (d.rt == REG_SP) || is_sp_pc(d.rm);
			end
		end
		return d;
	endfunction : decode_instr

	function automatic logic [31:0] sign_ext(input logic [31:0] v,
		input logic half);
		return half ? {{16{v[15]}}, v[15:0]} : {{24{v[7]}}, v[7:0]};
	endfunction : sign_ext

	// ****************************************************
	// decode and address forming
	// ****************************************************
	state_t state_r;
	state_t state_nxt;
	dec_t dec;
	dec_t dec_r;
	logic fire;
	logic exec;
	logic [1:0] ctrl_r;
	logic [NUM_EV-1:0] status_r;
	logic [NUM_EV-1:0] status_nxt;
	logic [NUM_EV-1:0] mask_r;
	logic [NUM_EV-1:0] ev;
	logic [NUM_EV-1:0] w1c;
	logic [31:0] base;
	logic [31:0] offset;
	logic [31:0] off_addr;
	logic [31:0] base_r;
	logic [31:0] offset_r;
	logic [31:0] off_addr_r;
	logic [31:0] last_addr_r;
	logic [31:0] load_count_r;

	assign fire = issue_valid && issue_ready_r;
	assign dec = decode_instr(instr, instr_wide);
	// loads run unless unpredictable and trapping is on
	assign exec = (dec.op == OP_USB || dec.op == OP_SB_LIT ||
		dec.op == OP_SH_IMM || dec.op == OP_SH_LIT ||
		dec.op == OP_SH_REG) && !(dec.unpred && ctrl_r[CTRL_TRAP_BIT]);

	// literal base is the word-aligned pc
	assign base = dec.lit ? {pc_val[31:2], 2'b00} : base_val;
	// lsl by 0-3 never needs the carry in and writes no flags
	assign offset = dec.reg_form ? (off_val << dec.shift)
		: {20'h00000, dec.imm};
	assign off_addr = dec.add ? base + offset : base - offset;

	// ****************************************************
	// sequencing
	// ****************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (fire && exec) begin
					state_nxt = S_REQ;
				end
			end
			S_REQ: begin
				if (mem_req_ready) begin
					state_nxt = S_WAIT;
				end
			end
			S_WAIT: begin
				if (mem_resp_valid) begin
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// state and issue handshake
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			issue_ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			issue_ready_r <= (state_nxt == S_IDLE) && ctrl_r[CTRL_EN_BIT];
		end
	end

	// operands captured at issue
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dec_r <= '0;
			base_r <= 32'h00000000;
			offset_r <= 32'h00000000;
			off_addr_r <= 32'h00000000;
		end else if (fire) begin
			dec_r <= dec;
			base_r <= base;
			offset_r <= offset;
			off_addr_r <= off_addr;
		end
	end

	// load request to the load unit
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_req_valid_r <= 1'b0;
			mem_req_r <= '0;
		end else if (fire && exec) begin
			mem_req_valid_r <= 1'b1;
			mem_req_r.addr <= dec.index ? off_addr : base;
			mem_req_r.half <= dec.half;
			mem_req_r.unpriv <= dec.unpriv;
		end else if (state_r == S_REQ && mem_req_ready) begin
			mem_req_valid_r <= 1'b0;
		end
	end

	// writeback; on a fault nothing is written
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rt_wb_r <= '0;
			rn_wb_r <= '0;
			done_r <= 1'b0;
		end else begin
			rt_wb_r.we <= 1'b0;
			rn_wb_r.we <= 1'b0;
			done_r <= fire && !exec;
			if (state_r == S_WAIT && mem_resp_valid) begin
				done_r <= 1'b1;
				rt_wb_r.we <= !mem_fault;
				rt_wb_r.idx <= dec_r.rt;
				rt_wb_r.data <= sign_ext(mem_rdata, dec_r.half);
				rn_wb_r.we <= !mem_fault && dec_r.wback;
				rn_wb_r.idx <= dec_r.rn;
				rn_wb_r.data <= off_addr_r;
			end
		end
	end

	// ****************************************************
	// events, status, interrupt
	// ****************************************************
	always_comb begin
		ev = '0;
		ev[EV_HINT] = fire && dec.op == OP_HINT;
		ev[EV_FOREIGN] = fire && dec.op == OP_FOREIGN;
		ev[EV_UNDEF] = fire && (dec.op == OP_UNDEF || dec.op == OP_NONE);
		ev[EV_UNPRED] = fire && dec.unpred;
		ev[EV_FAULT] = state_r == S_WAIT && mem_resp_valid && mem_fault;
		ev[EV_DONE] = state_r == S_WAIT && mem_resp_valid && !mem_fault;
	end

	// set wins over a same-cycle write-one clear
	assign status_nxt = (status_r & ~w1c) | ev;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status_r <= '0;
			irq_r <= 1'b0;
			last_addr_r <= 32'h00000000;
			load_count_r <= 32'h00000000;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & mask_r);
			if (fire && exec) begin
				last_addr_r <= dec.index ? off_addr : base;
			end
			if (ev[EV_DONE]) begin
				load_count_r <= load_count_r + 32'h00000001;
			end
		end
	end

	// ****************************************************
	// apb slave, one wait state per access
	// ****************************************************
	logic acc;
	logic hit;
	logic [7:0] word_addr;

	assign acc = psel && penable && pready;
	assign word_addr = 8'(paddr);
	assign hit = word_addr == OFF_CTRL || word_addr == OFF_STATUS ||
		word_addr == OFF_MASK || word_addr == OFF_LAST_ADDR ||
		word_addr == OFF_LOAD_COUNT;
	assign w1c = (acc && pwrite && word_addr == OFF_STATUS)
		? pwdata[NUM_EV-1:0] : '0;

	// control and mask writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= CTRL_RESET;
			mask_r <= MASK_RESET;
		end else if (acc && pwrite) begin
			if (word_addr == OFF_CTRL) begin
				ctrl_r <= pwdata[1:0];
			end
			if (word_addr == OFF_MASK) begin
				mask_r <= pwdata[NUM_EV-1:0];
			end
		end
	end

	// ready, read data and error answer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			prdata <= 32'h00000000;
			if (psel && penable && !pready && !pwrite) begin
				case (word_addr)
					OFF_CTRL: prdata <= {30'h0, ctrl_r};
					OFF_STATUS: prdata <= {26'h0, status_r};
					OFF_MASK: prdata <= {26'h0, mask_r};
					OFF_LAST_ADDR: prdata <= last_addr_r;
					OFF_LOAD_COUNT: prdata <= load_count_r;
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_BYTE_SIGNEXT: assert property (
		rt_wb_r.we && !dec_r.half |->
		rt_wb_r.data == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
		else $error("byte load not sign-extended");
	AST_USB_ADDR: assert property (
		$rose(mem_req_valid_r) && dec_r.op == OP_USB |->
		mem_req_r.unpriv && mem_req_r.addr == base_r + {24'h0, dec_r.imm[7:0]})
		else $error("unpriv byte address or rights wrong");
	AST_BYTE_LIT: assert property (
		fire && instr_wide && instr[31:20] == HW1_USB &&
		instr[19:16] == REG_PC && instr[15:12] != REG_PC |=>
		dec_r.op == OP_SB_LIT)
		else $error("byte literal not decoded");
	AST_UNPRED: assert property (
		fire && dec.op == OP_USB && is_sp_pc(dec.rt) |=> status_r[EV_UNPRED])
		else $error("unpredictable destination not flagged");
	AST_POST_INDEX: assert property (
		$rose(mem_req_valid_r) && !dec_r.index |-> mem_req_r.addr == base_r)
		else $error("post-indexed load used offset address");
	AST_WBACK: assert property (
		rn_wb_r.we |-> rn_wb_r.idx == dec_r.rn && rn_wb_r.data ==
		(dec_r.add ? base_r + offset_r : base_r - offset_r))
		else $error("writeback value wrong");
	AST_HALF_SIGNEXT: assert property (
		rt_wb_r.we && dec_r.half |->
		rt_wb_r.data == {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
		else $error("halfword load not sign-extended");
	AST_LIT_ALIGN: assert property (
		$rose(mem_req_valid_r) && dec_r.op == OP_SH_LIT |->
		base_r[1:0] == 2'b00 && mem_req_r.addr == (dec_r.add
		? base_r + {20'h0, dec_r.imm} : base_r - {20'h0, dec_r.imm}))
		else $error("literal address wrong");
	AST_HINT_NOP: assert property (
		fire && dec.op == OP_HINT |=> done_r && !mem_req_valid_r ##1
		!rt_wb_r.we && !rn_wb_r.we)
		else $error("hint did more than nothing");
	AST_REG_NOWB: assert property (
		dec_r.reg_form |-> !rn_wb_r.we)
		else $error("register form wrote back base");
	AST_SHIFT: assert property (
		$rose(mem_req_valid_r) && dec_r.reg_form |->
		mem_req_r.addr == base_r + offset_r &&
		offset_r == ($past(off_val) << dec_r.shift))
		else $error("register offset shift wrong");

endmodule : narrow_load_decode

// [verification/load_unit_model.sv]
// load side model answering the narrow load decoder
// assumes one request in flight; lat, rd_val and flt come from the bench
`timescale 1ns/100ps
module load_unit_model
	import narrow_load_pkg::*;
(
	input wire logic clk,
	input wire logic mem_req_valid_r,
	input wire mem_req_t mem_req_r,
	input wire logic [3:0] lat,
	input wire logic [31:0] rd_val,
	input wire logic flt,
	output logic mem_req_ready,
	output logic mem_resp_valid,
	output logic [31:0] mem_rdata,
	output logic mem_fault,
	output mem_req_t seen,
	output logic [7:0] n_acc
);
	// ****************************************
	// accept after lat cycles, answer lat later
	// ****************************************
	initial begin
		mem_req_ready = 1'b0;
		mem_resp_valid = 1'b0;
		mem_rdata = 32'hffffffff;
		mem_fault = 1'b0;
		seen = '0;
		n_acc = 8'h00;
		forever begin
			@(posedge clk);
			if (mem_req_valid_r === 1'b1) begin
				repeat (lat) @(posedge clk);
				mem_req_ready <= 1'b1;
				@(posedge clk);
				seen <= mem_req_r;
				n_acc <= n_acc + 8'h01;
				mem_req_ready <= 1'b0;
				repeat (lat) @(posedge clk);
				// data low aligned, upper bits left noisy
				mem_resp_valid <= 1'b1;
				mem_rdata <= rd_val;
				mem_fault <= flt;
				@(posedge clk);
				mem_resp_valid <= 1'b0;
				mem_rdata <= ~rd_val; // released bus shows the inverse
				mem_fault <= 1'b0;
			end
		end
	end
endmodule : load_unit_model

// [verification/narrow_load_decode_tb_top.sv]
// self-checking bench for the narrow load decoder and its apb registers
// assumes load_unit_model on the load side, no input tied off
`timescale 1ns/100ps
module narrow_load_decode_tb_top
	import narrow_load_pkg::*;
();
	logic clk, rst_b, issue_valid, issue_ready_r, instr_wide, done_r, irq_r;
	logic psel, penable, pwrite, pready, pslverr, err, flt;
	logic mem_req_valid_r, mem_req_ready, mem_resp_valid, mem_fault;
	logic [31:0] instr, base_val, off_val, pc_val, pwdata, prdata;
	logic [31:0] mem_rdata, rd_val, rd;
	logic [7:0] paddr, n_acc;
	logic [3:0] lat;
	mem_req_t mem_req_r, seen;
	wb_t rt_wb_r, rn_wb_r, rt_got, rn_got;
	int n_errors, checks;

	narrow_load_decode #(.ADDR_W(8)) narrow_load_decode_inst (.clk, .rst_b,
		.issue_valid, .issue_ready_r, .instr, .instr_wide, .base_val,
		.off_val, .pc_val, .mem_req_valid_r, .mem_req_r, .mem_req_ready,
		.mem_resp_valid, .mem_rdata, .mem_fault, .rt_wb_r, .rn_wb_r, .done_r,
		.irq_r, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	load_unit_model load_unit_model_inst (.clk, .mem_req_valid_r, .mem_req_r,
		.lat, .rd_val, .flt, .mem_req_ready, .mem_resp_valid, .mem_rdata,
		.mem_fault, .seen, .n_acc);

	// ****************************************
	// encodings, bus tasks and comparison
	// ****************************************
	function automatic logic [31:0] e_usb(logic [3:0] n, t, logic [7:0] i);
		return {HW1_USB, n, t, HW2_UNPRIV, i};
	endfunction : e_usb
	function automatic logic [31:0] e_h12(logic [3:0] n, t, logic [11:0] i);
		return {HW1_SH_LONG_OFFSET_FIELD, n, t, i};
	endfunction : e_h12
	function automatic logic [31:0] e_h8(logic [3:0] n, t, logic [2:0] puw,
		logic [7:0] i);
		return {HW1_SH_MAIN, n, t, 1'b1, puw, i};
	endfunction : e_h8
	function automatic logic [31:0] e_lit(logic u, logic [3:0] t,
		logic [11:0] i);
		return {HW1_LOAD_HI, u, HW1_HALF_LO, REG_PC, t, i};
	endfunction : e_lit
	function automatic logic [31:0] e_hr(logic [3:0] n, t, logic [1:0] s,
		logic [3:0] m);
		return {HW1_SH_MAIN, n, t, 6'h00, s, m};
	endfunction : e_hr

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	// one apb transfer; result left in rd and err
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle limit here, only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// issue one instruction, wait for done, keep the writebacks
	task automatic run(input logic [31:0] ins, input logic w,
		input logic [31:0] b, o, p, d);
		@(posedge clk);
		instr <= ins;
		instr_wide <= w;
		base_val <= b;
		off_val <= o;
		pc_val <= p;
		rd_val <= d;
		issue_valid <= 1'b1;
		// pre-edge values: ready as taken, done pulse while it stands
		do begin
			@(posedge clk);
		end while (issue_ready_r !== 1'b1);
		issue_valid <= 1'b0;
		do begin
			@(posedge clk);
		end while (done_r !== 1'b1);
		rt_got = rt_wb_r;
		rn_got = rn_wb_r;
	endtask : run

	task automatic ck_load(input logic [31:0] a, input logic h, u,
		input logic [3:0] t, input logic [31:0] v);
		chk_val(seen.addr, a);
		chk_val({30'h0, seen.half, seen.unpriv}, {30'h0, h, u});
		chk_val({27'h0, rt_got.we, rt_got.idx}, {27'h0, 1'b1, t});
		chk_val(rt_got.data, v);
	endtask : ck_load

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk_val(rd, {30'h0, CTRL_RESET});
		apb(1'b0, OFF_MASK, 32'h0);
		chk_val(rd, {26'h0, MASK_RESET});
		apb(1'b0, 8'h14, 32'h0);
		chk_val({rd[30:0], err}, 32'h1);
		$display("test regs done");
	endtask : t_regs

	task automatic t_byte;
		run(e_usb(4'h2, 4'h3, 8'hff), 1'b1, 32'h1000, 0, 0, 32'h5a5a5a80);
		ck_load(32'h10ff, 1'b0, 1'b1, 4'h3, 32'hffffff80);
		run(e_usb(4'h2, 4'h4, 8'h00), 1'b1, 32'h1000, 0, 0, 32'h7f);
		ck_load(32'h1000, 1'b0, 1'b1, 4'h4, 32'h7f);
		run(e_usb(REG_PC, 4'h5, 8'h10), 1'b1, 32'h1000, 0, 32'h2003, 32'hff);
		ck_load(32'h11f0, 1'b0, 1'b0, 4'h5, 32'hffffffff);
		$display("test byte done");
	endtask : t_byte

	task automatic t_half;
		logic [2:0] tbl [5];
		logic [31:0] oa;
		tbl = '{3'b111, 3'b101, 3'b011, 3'b001, 3'b100};
		run(e_h12(4'h2, 4'h3, 12'hfff), 1'b1, 32'h10000, 0, 0, 32'h5a5a8001);
		ck_load(32'h10fff, 1'b1, 1'b0, 4'h3, 32'hffff8001);
		chk_val({31'h0, rn_got.we}, 32'h0);
		for (int k = 0; k < 5; k++) begin
			oa = tbl[k][1] ? 32'h10ff : 32'h0f01;
			run(e_h8(4'h2, 4'h3, tbl[k], 8'hff), 1'b1, 32'h1000, 0, 0,
				32'h12347fff);
			ck_load(tbl[k][2] ? oa : 32'h1000, 1'b1, 1'b0, 4'h3, 32'h7fff);
			chk_val({31'h0, rn_got.we}, {31'h0, tbl[k][0]});
			if (tbl[k][0]) begin
				chk_val(rn_got.data, oa);
			end
		end
		run(e_h8(REG_PC, 4'h3, 3'b111, 8'h10), 1'b1, 32'h1000, 0, 32'h2003,
			32'h8000);
		ck_load(32'h10f0, 1'b1, 1'b0, 4'h3, 32'hffff8000);
		run(e_lit(1'b1, 4'h3, 12'hffc), 1'b1, 0, 0, 32'h2003, 32'h1);
		ck_load(32'h2ffc, 1'b1, 1'b0, 4'h3, 32'h1);
		run(e_lit(1'b0, 4'h3, 12'h004), 1'b1, 0, 0, 32'h2003, 32'h1);
		ck_load(32'h1ffc, 1'b1, 1'b0, 4'h3, 32'h1);
		$display("test half done");
	endtask : t_half

	task automatic t_reg;
		@(posedge clk);
		lat <= 4'h3;
		run({16'h0, OP16_SH_REG, 9'h053}, 1'b0, 32'h1000, 32'h22, 0, 32'h8000);
		ck_load(32'h1022, 1'b1, 1'b0, 4'h3, 32'hffff8000);
		chk_val({31'h0, rn_got.we}, 32'h0);
		for (int s = 0; s < 4; s++) begin
			run(e_hr(4'h2, 4'h3, s[1:0], 4'h4), 1'b1, 32'h1000, 32'h40000011,
				0, 32'h1);
			ck_load(32'h1000 + (32'h40000011 << s), 1'b1, 1'b0, 4'h3,
				32'h1);
		end
		apb(1'b0, OFF_LAST_ADDR, 32'h0);
		chk_val(rd, 32'h1088);
		// clean loads so far: 3 byte, 9 halfword, 5 register form
		apb(1'b0, OFF_LOAD_COUNT, 32'h0);
		chk_val(rd, 32'h00000011);
		$display("test reg done");
	endtask : t_reg

	task automatic t_events;
		logic [31:0] enc [13];
		int ev [13];
		logic [7:0] na;
		enc = '{e_usb(4'h2, REG_SP, 8'h1), e_usb(4'h2, REG_PC, 8'h1),
			e_h12(4'h2, REG_SP, 12'h1), e_h8(4'h2, REG_PC, 3'b111, 8'h1),
			e_h8(4'h3, 4'h3, 3'b111, 8'h1), e_lit(1'b1, REG_SP, 12'h1),
			e_hr(4'h2, REG_SP, 2'h0, 4'h1), e_hr(4'h2, 4'h3, 2'h0, REG_SP),
			e_hr(4'h2, 4'h3, 2'h0, REG_PC), e_h12(4'h2, REG_PC, 12'h1),
			e_h8(4'h2, REG_PC, 3'b100, 8'h1), e_h8(4'h2, 4'h3, 3'b010, 8'h1),
			e_h8(4'h2, 4'h3, 3'b110, 8'h1)};
		ev = '{9: EV_HINT, 10: EV_HINT, 11: EV_UNDEF, 12: EV_FOREIGN,
			default: EV_UNPRED};
		apb(1'b1, OFF_CTRL, 32'h3);
		for (int k = 0; k < 13; k++) begin
			apb(1'b1, OFF_STATUS, 32'h3f);
			na = n_acc;
			run(enc[k], 1'b1, 32'h1000, 32'h4, 0, 32'h0);
			chk_val({24'h0, n_acc}, {24'h0, na});
			chk_val({30'h0, rt_got.we, rn_got.we}, 32'h0);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk_val({31'h0, rd[ev[k]]}, 32'h1);
		end
		apb(1'b1, OFF_CTRL, 32'h1);
		@(posedge clk);
		flt <= 1'b1;
		run(e_usb(4'h2, 4'h3, 8'h5), 1'b1, 32'h1000, 0, 0, 32'h12);
		@(posedge clk);
		flt <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0);
		chk_val({30'h0, rt_got.we, rd[EV_FAULT]}, 32'h1);
		apb(1'b1, OFF_MASK, 32'h1 << EV_HINT);
		apb(1'b1, OFF_STATUS, 32'h3f);
		run(enc[9], 1'b1, 32'h1000, 0, 0, 32'h0);
		repeat (2) @(posedge clk);
		chk_val({31'h0, irq_r}, 32'h1);
		apb(1'b1, OFF_STATUS, 32'h1 << EV_HINT);
		repeat (2) @(posedge clk);
		chk_val({31'h0, irq_r}, 32'h0);
		$display("test events done");
	endtask : t_events

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_b, issue_valid, instr_wide, psel, penable, pwrite, flt} = '0;
		{instr, base_val, off_val, pc_val, pwdata, rd_val} = '0;
		paddr = 8'h00;
		lat = 4'h0;
		n_errors = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_byte;
		t_half;
		t_reg;
		t_events;
		conclude;
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		conclude;
	end
endmodule : narrow_load_decode_tb_top
